// ===== rtl/cfpm_pkg.sv
// Shared constants for the charger fault protection manager
package cfpm_pkg;
    // Clock and the microsecond tick
    localparam int CLK_PERIOD_NS = 5;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
    localparam int TICK_CNT_W = 8;
    localparam logic [TICK_CNT_W-1:0] TICK_LAST =
        TICK_CNT_W'(TICK_CYCLES - 1);
    // Times in their own unit; ticks assume a one-microsecond tick, not TICK_NS
    localparam int US_PER_MS = 1000;
    localparam int BOV_DEB_MS = 1;
    localparam int OT_DELAY_US = 100;
    localparam int WOC_SAMPLE_US = 10;
    localparam int WOC_WIN_MS = 50;
    localparam int RETRY_LONG_MS = 1300;
    localparam int RETRY_SHORT_MS = 150;
    localparam int BOV_DEB_TICKS = BOV_DEB_MS * US_PER_MS;
    localparam int OT_DELAY_TICKS = OT_DELAY_US;
    localparam int WOC_WIN_TICKS = WOC_WIN_MS * US_PER_MS;
    localparam int RETRY_LONG_TICKS = RETRY_LONG_MS * US_PER_MS;
    localparam int RETRY_SHORT_TICKS = RETRY_SHORT_MS * US_PER_MS;
    localparam int TMR_W = 21;
    localparam logic [3:0] WOC_SAMPLE_TICKS = 4'(WOC_SAMPLE_US);
    // Thresholds, millivolts and milliamps
    localparam logic [17:0] SOV_OFFSET_MV = 18'h00320;
    localparam logic [17:0] SOV_HYST_MV = 18'h0012C;
    localparam logic [15:0] WOC_ADP_LIMIT_MA = 16'h2EE0;
    localparam logic [15:0] WOC_BAT_LIMIT_MA = 16'h4E20;
    localparam logic [2:0] WOC_TRIP_COUNT = 3'h7;
    localparam logic [6:0] BOV_PCT_1CELL = 7'h04;
    localparam logic [6:0] BOV_PCT_MULTI = 7'h02;
    localparam logic [6:0] PCT_DIVISOR = 7'h64;
    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL2 = 8'h00;
    localparam logic [7:0] ADDR_SETUP = 8'h04;
    localparam logic [7:0] ADDR_STATE = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
    // Field positions
    localparam int CTRL2_BOV_DIS = 0;
    localparam int CTRL2_WOC_DIS = 1;
    localparam int CTRL2_RETRY_SHORT = 11;
    localparam int SETUP_CELLS_LSB = 16;
    // Reset values
    localparam logic [31:0] CTRL2_RESET = 32'h0000_0000;
    localparam logic [15:0] MAX_RAIL_RESET = 16'h20D0;
    localparam logic [1:0] CELLS_RESET = 2'h1;
    localparam logic [4:0] MASK_RESET = 5'h00;
    // Event bits in the interrupt status
    localparam int EV_BOV = 0;
    localparam int EV_SOV = 1;
    localparam int EV_WOC = 2;
    localparam int EV_OT = 3;
    localparam int EV_RETRY = 4;
    localparam int NUM_EV = 5;
    // Timer slots
    localparam int T_BOV = 0;
    localparam int T_OT = 1;
    localparam int T_WIN = 2;
    localparam int T_RETRY = 3;
    localparam int NUM_TMR = 4;
endpackage

// ===== rtl/cfpm_tmr_if.sv
// Control bundle between the manager and one interval timer
`timescale 1ns/1ps
interface cfpm_tmr_if;
    import cfpm_pkg::*;
    logic run;
    logic [TMR_W-1:0] limit;
    logic done;
    modport ctl (output run, output limit, input done);
    modport tmr (input run, input limit, output done);
endinterface

// ===== rtl/cfpm_tick.sv
// Divider giving a one-cycle pulse every microsecond
`timescale 1ns/1ps
module cfpm_tick import cfpm_pkg::*; (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Tick out
    output logic tick
);
    logic [TICK_CNT_W-1:0] count;
    wire wrap = (count == TICK_LAST);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
            tick <= 1'b0;
        end else begin
            count <= wrap ? '0 : count + 1'b1;
            tick <= wrap;
        end
    end
endmodule

// ===== rtl/cfpm_timer.sv
// Tick-driven interval timer, cleared whenever run drops
`timescale 1ns/1ps
module cfpm_timer import cfpm_pkg::*; (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tick,
    // Control bundle
    cfpm_tmr_if.tmr bus
);
    logic [TMR_W-1:0] count;
    wire reached = (count >= bus.limit);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
        end else if (!bus.run) begin
            count <= '0;
        end else if (tick && !reached) begin
            count <= count + 1'b1;
        end
    end

    // Done stays high while the timer is held running past its limit
    assign bus.done = bus.run && reached;
endmodule

// ===== rtl/cfpm_top.sv
// Charger fault protection manager with APB registers
// Operation
// - Battery over threshold 1ms flags, stops switching
// - Margin 4% single cell, 2% otherwise
// - Restart below half margin after 1ms
// - Control bit 0 disables battery protection
// - Rail 800mV over setting stops switching
// - Rail recovery 300mV lower, no long debounce
// - Trip on adapter 12A or battery 20A
// - Count at most once per 10us
// - Seven counts in 50ms shut input path
// - Retry after 1.3s or 150ms, bit 11
// - Control bit 1 disables overcurrent protection
// - Over 140 degrees stops switching
// - Restart below 120 degrees plus 100us
`timescale 1ns/1ps
module cfpm_top import cfpm_pkg::*; #(
    parameter int BOV_DEB_T = BOV_DEB_TICKS,
    parameter int OT_DELAY_T = OT_DELAY_TICKS,
    parameter int WOC_WIN_T = WOC_WIN_TICKS,
    parameter int RETRY_LONG_T = RETRY_LONG_TICKS,
    parameter int RETRY_SHORT_T = RETRY_SHORT_TICKS
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Sensed levels, already digitised
    input wire logic [15:0] battery_sense_mv,
    input wire logic [15:0] system_rail_sense,
    input wire logic [15:0] adapter_current_ma,
    input wire logic [15:0] battery_discharge_ma,
    // Junction temperature comparators
    input wire logic temp_above_hot,
    input wire logic temp_below_cool,
    // Power stage controls
    output logic switch_enable,
    output logic input_isolation_gate,
    output logic adapter_good_flag,
    output logic startup_request,
    // Interrupt
    output logic irq
);
    // Timer bundles and their shared tick
    logic tick;
    cfpm_tmr_if tif[NUM_TMR]();

    cfpm_tick u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick)
    );

    genvar gi;
    generate
        for (gi = 0; gi < NUM_TMR; gi++) begin : g_tmr
            cfpm_timer u_timer (
                .pclk(pclk),
                .presetn(presetn),
                .tick(tick),
                .bus(tif[gi])
            );
        end
    endgenerate

    // Software registers
    logic [31:0] second_control_reg;
    logic [15:0] max_rail_voltage_setting;
    logic [1:0] cell_count;
    logic [NUM_EV-1:0] irq_status;
    logic [NUM_EV-1:0] irq_mask;

    // Fault state
    logic bov_fault;
    logic sov_fault;
    logic woc_shutdown;
    logic ot_fault;
    logic [2:0] woc_count;
    logic [3:0] woc_sample;
    logic woc_counted;

    // APB decode
    wire setup_phase = psel && !penable;
    wire access = psel && penable;
    wire wr_access = access && pwrite;
    wire rd_access = access && !pwrite;
    wire hit_ctrl = (paddr == ADDR_CTRL2);
    wire hit_setup = (paddr == ADDR_SETUP);
    wire hit_state = (paddr == ADDR_STATE);
    wire hit_stat = (paddr == ADDR_IRQ_STAT);
    wire hit_mask = (paddr == ADDR_IRQ_MASK);
    wire mapped = hit_ctrl || hit_setup || hit_state || hit_stat ||
        hit_mask;

    wire bov_disable = second_control_reg[CTRL2_BOV_DIS];
    wire woc_disable = second_control_reg[CTRL2_WOC_DIS];
    wire retry_short = second_control_reg[CTRL2_RETRY_SHORT];

    // Battery overvoltage thresholds
    wire [6:0] bov_pct = (cell_count == 2'h0) ? BOV_PCT_1CELL :
        BOV_PCT_MULTI;
    wire [22:0] bov_product = {7'h00, max_rail_voltage_setting} *
        {16'h0000, bov_pct};
    wire [22:0] bov_margin_wide = bov_product / {16'h0000, PCT_DIVISOR};
    wire [17:0] bov_margin = bov_margin_wide[17:0];
    wire [17:0] max_rail_wide = {2'h0, max_rail_voltage_setting};
    wire [17:0] bov_trip_mv = max_rail_wide + bov_margin;
    wire [17:0] bov_release_mv = max_rail_wide + (bov_margin >> 1);
    wire [17:0] batt_wide = {2'h0, battery_sense_mv};
    wire bov_above = batt_wide > bov_trip_mv;
    wire bov_below = batt_wide < bov_release_mv;

    // System rail thresholds
    wire [17:0] sov_trip_mv = max_rail_wide + SOV_OFFSET_MV;
    wire [17:0] sov_release_mv = sov_trip_mv - SOV_HYST_MV;
    wire [17:0] rail_wide = {2'h0, system_rail_sense};
    wire sov_above = rail_wide > sov_trip_mv;
    wire sov_below = rail_wide < sov_release_mv;

    // Way-overcurrent comparison
    wire woc_trip = !woc_disable &&
        ((adapter_current_ma > WOC_ADP_LIMIT_MA) ||
        (battery_discharge_ma > WOC_BAT_LIMIT_MA));
    wire sample_end = tick && (woc_sample == WOC_SAMPLE_TICKS - 4'h1);
    wire woc_count_now = woc_trip && !woc_counted && !woc_shutdown;
    wire woc_reach = woc_count_now &&
        (woc_count == WOC_TRIP_COUNT - 3'h1);

    // Timer control
    assign tif[T_BOV].run = !bov_disable &&
        (bov_fault ? bov_below : bov_above);
    assign tif[T_BOV].limit = TMR_W'(BOV_DEB_T);
    assign tif[T_OT].run = ot_fault && temp_below_cool;
    assign tif[T_OT].limit = TMR_W'(OT_DELAY_T);
    assign tif[T_WIN].run = !woc_disable && (woc_count != 3'h0) &&
        !woc_shutdown;
    assign tif[T_WIN].limit = TMR_W'(WOC_WIN_T);
    assign tif[T_RETRY].run = woc_shutdown && !woc_disable;
    assign tif[T_RETRY].limit = retry_short ? TMR_W'(RETRY_SHORT_T) :
        TMR_W'(RETRY_LONG_T);

    wire bov_set = !bov_fault && tif[T_BOV].done;
    wire bov_clr = bov_fault && (tif[T_BOV].done || bov_disable);
    wire sov_set = !sov_fault && sov_above;
    wire ot_set = !ot_fault && temp_above_hot;
    wire retry_done = tif[T_RETRY].done;

    // Battery overvoltage: flag after debounce, release after debounce
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bov_fault <= 1'b0;
        end else if (bov_set) begin
            bov_fault <= 1'b1;
        end else if (bov_clr) begin
            bov_fault <= 1'b0;
        end
    end

    // System overvoltage recovers on hysteresis only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sov_fault <= 1'b0;
        end else if (sov_set) begin
            sov_fault <= 1'b1;
        end else if (sov_fault && sov_below) begin
            sov_fault <= 1'b0;
        end
    end

    // Over-temperature; a new hot report restarts the cool-down wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ot_fault <= 1'b0;
        end else if (ot_set) begin
            ot_fault <= 1'b1;
        end else if (ot_fault && tif[T_OT].done && !temp_above_hot) begin
            ot_fault <= 1'b0;
        end
    end

    // Sample interval: one count allowed per interval
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            woc_sample <= '0;
            woc_counted <= 1'b0;
        end else begin
            if (sample_end) begin
                woc_sample <= '0;
            end else if (tick) begin
                woc_sample <= woc_sample + 4'h1;
            end
            if (sample_end) begin
                woc_counted <= 1'b0;
            end else if (woc_count_now) begin
                woc_counted <= 1'b1;
            end
        end
    end

    // Count inside the window; the window restarts from the first count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            woc_count <= '0;
        end else if (woc_disable || woc_reach || tif[T_WIN].done) begin
            woc_count <= '0;
        end else if (woc_count_now) begin
            woc_count <= woc_count + 3'h1;
        end
    end

    // Shutdown holds until the retry wait expires
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            woc_shutdown <= 1'b0;
        end else if (woc_disable || retry_done) begin
            woc_shutdown <= 1'b0;
        end else if (woc_reach) begin
            woc_shutdown <= 1'b1;
        end
    end

    // Power stage outputs; the gate reacts in the cycle after the count
    wire any_fault = bov_fault || sov_fault || woc_shutdown || ot_fault ||
        woc_reach || bov_set || sov_set || ot_set;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            switch_enable <= 1'b0;
            input_isolation_gate <= 1'b0;
            adapter_good_flag <= 1'b0;
            startup_request <= 1'b0;
        end else begin
            switch_enable <= !any_fault;
            input_isolation_gate <= !(woc_shutdown || woc_reach);
            adapter_good_flag <= !(woc_shutdown || woc_reach);
            startup_request <= retry_done && !woc_disable;
        end
    end

    // Interrupt events; a set in the clearing cycle wins
    wire [NUM_EV-1:0] events = {retry_done && !woc_disable, ot_set,
        woc_reach, sov_set, bov_set};
    wire stat_read = rd_access && hit_stat;
    // Clear only what the reader saw; events after the setup edge survive
    wire [NUM_EV-1:0] stat_clear = stat_read ? prdata[NUM_EV-1:0] : '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= '0;
            irq <= 1'b0;
        end else begin
            irq_status <= (irq_status & ~stat_clear) | events;
            irq <= |(irq_status & irq_mask);
        end
    end

    // Writes take effect in the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            second_control_reg <= CTRL2_RESET;
            max_rail_voltage_setting <= MAX_RAIL_RESET;
            cell_count <= CELLS_RESET;
            irq_mask <= MASK_RESET;
        end else if (wr_access) begin
            if (hit_ctrl) begin
                second_control_reg <= pwdata;
            end else if (hit_setup) begin
                max_rail_voltage_setting <= pwdata[15:0];
                cell_count <= pwdata[SETUP_CELLS_LSB+1:SETUP_CELLS_LSB];
            end else if (hit_mask) begin
                irq_mask <= pwdata[NUM_EV-1:0];
            end
        end
    end

    // Read data are captured at setup so they stand in the access phase
    wire [31:0] state_word = {22'h000000, woc_count, woc_shutdown,
        ot_fault, sov_fault, bov_fault, switch_enable, 2'h0};
    logic [31:0] rd_mux;

    always_comb begin
        if (hit_ctrl) begin
            rd_mux = second_control_reg;
        end else if (hit_setup) begin
            rd_mux = {14'h0000, cell_count, max_rail_voltage_setting};
        end else if (hit_state) begin
            rd_mux = state_word;
        end else if (hit_stat) begin
            rd_mux = {27'h0000000, irq_status};
        end else if (hit_mask) begin
            rd_mux = {27'h0000000, irq_mask};
        end else begin
            rd_mux = 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            pready <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (setup_phase) begin
                prdata <= pwrite ? 32'h0000_0000 : rd_mux;
                pslverr <= !mapped;
            end
        end
    end
endmodule

// ===== tb/cfpm_props.sv
// Checker for the charger fault protection manager
`timescale 1ns/1ps
module cfpm_props import cfpm_pkg::*; #(
    parameter int BOV_DEB_T = 20
) (
    // Clock, reset and register writes
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    // Sensed levels
    input wire logic [15:0] battery_sense_mv,
    input wire logic [15:0] system_rail_sense,
    input wire logic [15:0] adapter_current_ma,
    input wire logic [15:0] battery_discharge_ma,
    input wire logic temp_above_hot,
    // Power stage controls
    input wire logic switch_enable,
    input wire logic input_isolation_gate,
    input wire logic adapter_good_flag,
    input wire logic startup_request
);
    // Tick phase and sampling slack on top of the debounce
    localparam int BOV_MAX = (BOV_DEB_T + 2) * TICK_CYCLES + 4;
    localparam int WOC_MAX = 72 * TICK_CYCLES;
    logic [15:0] max_mv;
    logic one_cell, bov_dis, woc_dis;
    logic [31:0] bov_cnt, woc_cnt;
    wire wr = psel && penable && pready && pwrite;
    wire [17:0] pct = 18'(one_cell ? BOV_PCT_1CELL : BOV_PCT_MULTI);
    wire [17:0] margin = 18'(max_mv) * pct / 18'(PCT_DIVISOR);
    wire bov_hi = 18'(battery_sense_mv) > 18'(max_mv) + margin;
    wire sov_hi = 18'(system_rail_sense) > 18'(max_mv) + SOV_OFFSET_MV;
    wire trip = adapter_current_ma > WOC_ADP_LIMIT_MA ||
        battery_discharge_ma > WOC_BAT_LIMIT_MA;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            max_mv <= MAX_RAIL_RESET;
            one_cell <= (CELLS_RESET == 2'h0);
            bov_dis <= 1'b0;
            woc_dis <= 1'b0;
            bov_cnt <= 32'h0;
            woc_cnt <= 32'h0;
        end else begin
            if (wr && paddr == ADDR_SETUP) begin
                max_mv <= pwdata[15:0];
                one_cell <= (pwdata[17:16] == 2'h0);
            end
            if (wr && paddr == ADDR_CTRL2) begin
                bov_dis <= pwdata[CTRL2_BOV_DIS];
                woc_dis <= pwdata[CTRL2_WOC_DIS];
            end
            bov_cnt <= (bov_hi && !bov_dis) ? bov_cnt + 32'h1 : 32'h0;
            woc_cnt <= (trip && !woc_dis && input_isolation_gate) ?
                woc_cnt + 32'h1 : 32'h0;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_bov_time;
        bov_cnt > BOV_MAX |-> !switch_enable;
    endproperty
    a_bov_time: assert property (p_bov_time)
        else $error("battery overvoltage did not stop switching");
    property p_sov_stop;
        sov_hi |-> ##[1:2] !switch_enable;
    endproperty
    a_sov_stop: assert property (p_sov_stop)
        else $error("rail overvoltage did not stop switching");
    property p_ot_stop;
        temp_above_hot |-> ##[1:2] !switch_enable;
    endproperty
    a_ot_stop: assert property (p_ot_stop)
        else $error("over temperature did not stop switching");
    property p_sw_rise;
        $rose(switch_enable) |-> !$past(temp_above_hot) && !$past(sov_hi);
    endproperty
    a_sw_rise: assert property (p_sw_rise)
        else $error("switching resumed during a fault");
    property p_shut_all;
        $fell(input_isolation_gate) |-> !adapter_good_flag && !switch_enable;
    endproperty
    a_shut_all: assert property (p_shut_all)
        else $error("shutdown left a path on");
    property p_gate_pair;
        adapter_good_flag == input_isolation_gate;
    endproperty
    a_gate_pair: assert property (p_gate_pair)
        else $error("gate and adapter flag disagree");
    property p_pulse;
        startup_request |=> !startup_request;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("start-up request longer than one cycle");
    property p_woc_dis;
        woc_dis && input_isolation_gate |=> input_isolation_gate;
    endproperty
    a_woc_dis: assert property (p_woc_dis)
        else $error("disabled overcurrent still shut the gate");
    property p_woc_time;
        woc_cnt <= WOC_MAX;
    endproperty
    a_woc_time: assert property (p_woc_time)
        else $error("sustained overcurrent never shut down");
endmodule

// ===== tb/cfpm_stage_model.sv
// Power stage and comparator model feeding the manager
`timescale 1ns/1ps
module cfpm_stage_model (
    // Levels requested by the bench
    input wire logic [15:0] bat_set,
    input wire logic [15:0] rail_set,
    input wire logic [15:0] adp_set,
    input wire logic [15:0] dis_set,
    input wire logic [7:0] temp_c,
    // Digitised levels and comparator flags
    output logic [15:0] battery_sense_mv,
    output logic [15:0] system_rail_sense,
    output logic [15:0] adapter_current_ma,
    output logic [15:0] battery_discharge_ma,
    output logic temp_above_hot,
    output logic temp_below_cool
);
    // Ideal converters: no noise, so timing windows stay exact
    localparam logic [7:0] HOT_C = 8'h8C;
    localparam logic [7:0] COOL_C = 8'h78;
    assign battery_sense_mv = bat_set;
    assign system_rail_sense = rail_set;
    assign adapter_current_ma = adp_set;
    assign battery_discharge_ma = dis_set;
    assign temp_above_hot = temp_c > HOT_C;
    assign temp_below_cool = temp_c < COOL_C;
endmodule

// ===== tb/tb.sv
// Testbench for the charger fault protection manager
`timescale 1ns/1ps
module tb import cfpm_pkg::*;;
    localparam int TC = TICK_CYCLES;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr, temp_c;
    logic [31:0] pwdata, prdata, r;
    logic [15:0] bat_set, rail_set, adp_set, dis_set, bat, rail, adp, dis;
    logic hot, cool, sw, gate, agf, start_req, irq, e;
    int err_total, n_checks, n;
    cfpm_top #(.BOV_DEB_T(20), .OT_DELAY_T(5), .WOC_WIN_T(200),
        .RETRY_LONG_T(60), .RETRY_SHORT_T(30)) dut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .battery_sense_mv(bat),
        .system_rail_sense(rail), .adapter_current_ma(adp),
        .battery_discharge_ma(dis), .temp_above_hot(hot),
        .temp_below_cool(cool), .switch_enable(sw),
        .input_isolation_gate(gate), .adapter_good_flag(agf),
        .startup_request(start_req), .irq(irq));
    cfpm_stage_model stage (.bat_set(bat_set), .rail_set(rail_set),
        .adp_set(adp_set), .dis_set(dis_set), .temp_c(temp_c),
        .battery_sense_mv(bat), .system_rail_sense(rail),
        .adapter_current_ma(adp), .battery_discharge_ma(dis),
        .temp_above_hot(hot), .temp_below_cool(cool));
    task stop_test;
        if (err_total == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
            err_total++;
        end
    endtask
    task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge: a following call must not drive psel in this step
        @(posedge pclk);
    endtask
    task ticks(input int k);
        repeat (k * TC) @(posedge pclk);
    endtask
    // Waits for the gate to drop (pick 0) or the start-up pulse (pick 1)
    task wait_for(input logic pick, input int lim);
        n = 0;
        while (n < lim) begin
            @(posedge pclk);
            n++;
            if (pick ? start_req === 1'b1 : gate === 1'b0) break;
        end
    endtask
    task t_regs;
        apb(ADDR_CTRL2, 1'b0, 32'h0);
        chk(r, CTRL2_RESET);
        apb(ADDR_SETUP, 1'b0, 32'h0);
        chk(r, {14'h0, CELLS_RESET, MAX_RAIL_RESET});
        apb(ADDR_IRQ_MASK, 1'b0, 32'h0);
        chk(r, 32'(MASK_RESET));
        apb(8'h14, 1'b0, 32'h0);
        chk({r[30:0], e}, 32'h1);
    endtask
    task t_sov;
        rail_set <= 16'h23F1;
        repeat (4) @(posedge pclk);
        chk(sw, 1'b0);
        chk(irq, 1'b0);
        rail_set <= 16'h22C4;
        ticks(2);
        chk(sw, 1'b0);
        rail_set <= 16'h22C3;
        repeat (4) @(posedge pclk);
        chk(sw, 1'b1);
        rail_set <= 16'h20D0;
    endtask
    task t_bov;
        bat_set <= 16'h2179;
        ticks(15);
        chk(sw, 1'b1);
        ticks(7);
        chk(sw, 1'b0);
        bat_set <= 16'h2124;
        ticks(22);
        chk(sw, 1'b0);
        bat_set <= 16'h2123;
        ticks(15);
        chk(sw, 1'b0);
        ticks(7);
        chk(sw, 1'b1);
        apb(ADDR_SETUP, 1'b1, 32'h0000_20D0);
        bat_set <= 16'h21FC;
        ticks(22);
        chk(sw, 1'b1);
        bat_set <= 16'h2221;
        ticks(22);
        chk(sw, 1'b0);
        apb(ADDR_CTRL2, 1'b1, 32'h1);
        repeat (4) @(posedge pclk);
        chk(sw, 1'b1);
        bat_set <= 16'h2328;
        ticks(22);
        chk(sw, 1'b1);
        bat_set <= 16'h1F40;
        apb(ADDR_CTRL2, 1'b1, 32'h0);
        apb(ADDR_SETUP, 1'b1, 32'h0001_20D0);
    endtask
    task t_ot;
        temp_c <= 8'h8C;
        repeat (4) @(posedge pclk);
        chk(sw, 1'b1);
        temp_c <= 8'h8D;
        repeat (4) @(posedge pclk);
        chk(sw, 1'b0);
        temp_c <= 8'h82;
        ticks(10);
        chk(sw, 1'b0);
        temp_c <= 8'h77;
        ticks(3);
        chk(sw, 1'b0);
        ticks(4);
        chk(sw, 1'b1);
    endtask
    task t_woc(input logic shrt, input int rt, input logic [1:0] path);
        apb(ADDR_CTRL2, 1'b1, {20'h0, shrt, 11'h0});
        apb(ADDR_IRQ_STAT, 1'b0, 32'h0);
        // Trip starts with the wait, so n runs from the first count
        adp_set <= path[0] ? 16'h2EE1 : 16'h0000;
        dis_set <= path[1] ? 16'h4E21 : 16'h0000;
        wait_for(1'b0, 80 * TC);
        chk(n >= 50 * TC && n <= 72 * TC, 32'h1);
        chk({gate, agf, sw}, 32'h0);
        adp_set <= 16'h0;
        dis_set <= 16'h0;
        repeat (2) @(posedge pclk);
        chk(irq, 1'b1);
        apb(ADDR_IRQ_STAT, 1'b0, 32'h0);
        chk(r, 32'h4);
        repeat (3) @(posedge pclk);
        chk(irq, 1'b0);
        wait_for(1'b1, 70 * TC);
        chk(n >= (rt - 3) * TC && n <= (rt + 2) * TC, 32'h1);
        repeat (3) @(posedge pclk);
        chk({gate, agf}, 32'h3);
    endtask
    task t_woc_all;
        apb(ADDR_IRQ_MASK, 1'b1, 32'h1F);
        adp_set <= 16'h2EE0;
        ticks(25);
        apb(ADDR_STATE, 1'b0, 32'h0);
        chk(r[9:7], 3'h0);
        t_woc(1'b1, 30, 2'h1);
        t_woc(1'b0, 60, 2'h2);
        apb(ADDR_CTRL2, 1'b1, 32'h2);
        adp_set <= 16'h32C8;
        ticks(25);
        apb(ADDR_STATE, 1'b0, 32'h0);
        chk({r[9:7], gate}, 32'h1);
        adp_set <= 16'h0;
    endtask
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    // Longest path is about 80k cycles of tests
    always @(posedge pclk) begin
        if ($time > 64'd500000) begin
            err_total++;
            stop_test();
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {err_total, n_checks} = '0;
        bat_set = 16'h1F40;
        rail_set = 16'h20D0;
        adp_set = 16'h0;
        dis_set = 16'h0;
        temp_c = 8'h19;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_sov();
        t_bov();
        t_ot();
        t_woc_all();
        stop_test();
    end
endmodule
bind cfpm_top cfpm_props #(.BOV_DEB_T(BOV_DEB_T)) u_props (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .battery_sense_mv(battery_sense_mv),
    .system_rail_sense(system_rail_sense),
    .adapter_current_ma(adapter_current_ma),
    .battery_discharge_ma(battery_discharge_ma),
    .temp_above_hot(temp_above_hot), .switch_enable(switch_enable),
    .input_isolation_gate(input_isolation_gate),
    .adapter_good_flag(adapter_good_flag),
    .startup_request(startup_request));
